// [design/input_debounce.sv]
`timescale 1ns/1ps
`include "supervisor_params.svh"
module input_debounce (
  input  wire logic ref_clk,   // Clock
  input  wire logic nrst,      // Async reset
  input  wire logic rawIn,     // Synchronised level
  output logic      cleanOut   // Debounced level
);
  logic [15:0] stableCnt_reg;

  // Level must stand unchanged for a full window before it is taken
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stableCnt_reg <= 16'h0000;
      cleanOut      <= 1'b1;
    end else if (rawIn == cleanOut) begin
      stableCnt_reg <= 16'h0000;
    end else if (stableCnt_reg == `DEBOUNCE_CYC) begin
      cleanOut      <= rawIn;
      stableCnt_reg <= 16'h0000;
    end else begin
      stableCnt_reg <= stableCnt_reg + 16'h0001;
    end
  end
endmodule

// [design/supervisor_params.svh]
// Contract
// - Backup only when below trip and cell
// - Backup routes cell to RAM supply
// - Startup only from main supply
// - Select passes unless reset, then gated
// - Select high at reset stays high
// - Select low at reset held 12us
// - Low hold ends early on select high
// - Disconnected select driven high
// - Backup keeps reset, ignores inputs
// - Backup flag high only in backup
// - Reset while supply low, plus hold
// - Manual low resets, plus hold
// - Manual input debounced internally
// - Watchdog restarts on kick edges
// - Static kick emits reset pulse
// - Watchdog cleared when reset asserts
// - Static kick repeats pulses forever
// - Auxiliary low asserts reset
// - Auxiliary clear keeps hold time
// - Reset output style per variant
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH
`define CLK_PERIOD_NS        50
`define SELECT_HOLD_NS       12000
`define SELECT_HOLD_CYC      ((`SELECT_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_HOLD_MS        150
`define RESET_HOLD_CYC       ((`RESET_HOLD_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WATCHDOG_PERIOD_MS   1600
`define WATCHDOG_PERIOD_CYC  ((`WATCHDOG_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define DEBOUNCE_CYC         16'h4E20
`define CNT_W                32
`endif

// [design/supervisor_pkg.sv]
package supervisor_pkg;
  typedef enum {AUX_MANUAL, AUX_WATCHDOG, AUX_BACKUP_FLAG, AUX_UNDERVOLT} aux_type;
  typedef enum {OUT_PUSH_PULL_LOW, OUT_OPEN_DRAIN_LOW, OUT_OPEN_DRAIN_HIGH} rst_style_type;
  typedef struct packed {
    logic supplyBelowTrip;
    logic supplyBelowCell;
    logic mainPresent;
  } supply_type;
  typedef struct packed {
    logic out;
    logic oe;
  } pin_type;
endpackage

// [design/supply_supervisor.sv]
`timescale 1ns/1ps
`include "supervisor_params.svh"
module supply_supervisor
  import supervisor_pkg::*;
#(
  parameter aux_type       AUX_FUNC  = AUX_MANUAL,
  parameter rst_style_type RST_STYLE = OUT_PUSH_PULL_LOW,
  parameter int            RESET_HOLD_CYC      = `RESET_HOLD_CYC,
  parameter int            WATCHDOG_PERIOD_CYC = `WATCHDOG_PERIOD_CYC
) (
  input  wire logic ref_clk,            // 20 MHz timebase
  input  wire logic nrst,               // Async reset, active low
  input  wire supply_type supplyIn,     // Comparator outcomes
  input  wire logic manual_reset_n,     // Manual reset, active low
  input  wire logic watchdog_kick_in,   // Watchdog kick
  input  wire logic auxUnderIn,         // Aux voltage below reference
  input  wire logic chipSelIn_n,        // Chip select in, active low
  output logic      chipSelOut_n,       // Gated chip select, active low
  output pin_type   resetPin,           // Reset pin drive and enable
  output logic      backup_active_flag, // Backup mode status
  output logic      ramFromCell,        // RAM supply on backup cell
  output logic      ramFromMain         // RAM supply on main
);
  localparam int SEL_HOLD = `SELECT_HOLD_CYC;

  // Two-stage synchronisers for all pins
  logic [5:0] syncA_reg;
  logic [5:0] syncB_reg;
  wire  [5:0] rawPins = {supplyIn, manual_reset_n, watchdog_kick_in, auxUnderIn};
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      syncA_reg <= 6'h3F;
      syncB_reg <= 6'h3F;
    end else begin
      syncA_reg <= rawPins;
      syncB_reg <= syncA_reg;
    end
  end
  logic csA_reg;
  logic csB_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      csA_reg <= 1'b1;
      csB_reg <= 1'b1;
    end else begin
      csA_reg <= chipSelIn_n;
      csB_reg <= csA_reg;
    end
  end
  wire belowTrip = syncB_reg[5];
  wire belowCell = syncB_reg[4];
  wire mainOk    = syncB_reg[3];
  wire kickS     = syncB_reg[1];
  wire auxUnderS = syncB_reg[0];

  logic manualClean;
  input_debounce u_debounce (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .rawIn    (syncB_reg[2]),
    .cleanOut (manualClean)
  );

  // Startup latch: only main supply can bring the block up
  logic started_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      started_reg <= 1'b0;
    else if (mainOk && !belowTrip)
      started_reg <= 1'b1;
  end

  wire backupNext = started_reg && belowTrip && belowCell;
  logic backup_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      backup_reg         <= 1'b0;
      backup_active_flag <= 1'b0;
      ramFromCell        <= 1'b0;
      ramFromMain        <= 1'b0;
    end else begin
      backup_reg         <= backupNext;
      backup_active_flag <= (AUX_FUNC == AUX_BACKUP_FLAG) && backupNext;
      ramFromCell        <= backupNext;
      ramFromMain        <= !backupNext && (started_reg || mainOk);
    end
  end

  // Sources; backup mode masks the auxiliary inputs
  wire manualLow = (AUX_FUNC == AUX_MANUAL) && !manualClean && !backup_reg;
  wire auxLow    = (AUX_FUNC == AUX_UNDERVOLT) && auxUnderS && !backup_reg;
  wire levelSrc  = !started_reg || belowTrip || backup_reg || manualLow || auxLow;

  // Watchdog
  logic kickPrev_reg;
  logic [`CNT_W-1:0] wdCnt_reg;
  logic wdFire;
  logic resetAct_reg;
  wire kickEdge = (kickS != kickPrev_reg) && !backup_reg;
  assign wdFire = (AUX_FUNC == AUX_WATCHDOG) && !resetAct_reg
                  && (wdCnt_reg == `CNT_W'(WATCHDOG_PERIOD_CYC - 1));
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      kickPrev_reg <= 1'b0;
      wdCnt_reg    <= '0;
    end else begin
      kickPrev_reg <= kickS;
      if (AUX_FUNC != AUX_WATCHDOG || resetAct_reg || kickEdge)
        wdCnt_reg <= '0;
      else
        wdCnt_reg <= wdCnt_reg + `CNT_W'(1);
    end
  end

  // Reset hold stretcher
  logic [`CNT_W-1:0] holdCnt_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      resetAct_reg <= 1'b1;
      holdCnt_reg  <= '0;
    end else if (levelSrc || wdFire) begin
      resetAct_reg <= 1'b1;
      holdCnt_reg  <= `CNT_W'(RESET_HOLD_CYC - 1);
    end else if (holdCnt_reg != '0) begin
      holdCnt_reg  <= holdCnt_reg - `CNT_W'(1);
    end else begin
      resetAct_reg <= 1'b0;
    end
  end

  // Output style selected at build
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // Asserted level of the chosen style while held in reset
      resetPin <= '{out: (RST_STYLE == OUT_OPEN_DRAIN_HIGH), oe: 1'b1};
    end else begin
      unique case (RST_STYLE)
        OUT_PUSH_PULL_LOW:   resetPin <= '{out: !resetAct_reg, oe: 1'b1};
        OUT_OPEN_DRAIN_LOW:  resetPin <= '{out: 1'b0, oe: resetAct_reg};
        OUT_OPEN_DRAIN_HIGH: resetPin <= '{out: 1'b1, oe: resetAct_reg};
      endcase
    end
  end

  // Chip-select gate; hold state captured as reset asserts
  logic resetPrev_reg;
  logic selHold_reg;
  logic [9:0] selCnt_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      resetPrev_reg <= 1'b1;
      selHold_reg   <= 1'b0;
      selCnt_reg    <= 10'h000;
    end else begin
      resetPrev_reg <= resetAct_reg;
      if (resetAct_reg && !resetPrev_reg && !csB_reg && !backup_reg) begin
        selHold_reg <= 1'b1;
        selCnt_reg  <= 10'(SEL_HOLD - 1);
      end else if (selHold_reg) begin
        if (csB_reg || selCnt_reg == 10'h000 || backup_reg)
          selHold_reg <= 1'b0;
        else
          selCnt_reg <= selCnt_reg - 10'h001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      chipSelOut_n <= 1'b1;
    else if (!resetAct_reg)
      chipSelOut_n <= csB_reg;
    else if (resetPrev_reg == 1'b0 && !csB_reg && !backup_reg)
      chipSelOut_n <= 1'b0;
    else if (selHold_reg && !csB_reg && selCnt_reg != 10'h000)
      chipSelOut_n <= 1'b0;
    else
      chipSelOut_n <= 1'b1;
  end

  property p_backup_route;
    @(posedge ref_clk) disable iff (!nrst) backup_reg |-> ramFromCell && !ramFromMain;
  endproperty
  a_backup_route: assert property (p_backup_route) else $error("cell not routed");
  property p_flag_only_backup;
    @(posedge ref_clk) disable iff (!nrst) backup_active_flag |-> backup_reg;
  endproperty
  a_flag_only_backup: assert property (p_flag_only_backup) else $error("flag outside backup");
  property p_start_main;
    @(posedge ref_clk) disable iff (!nrst) !started_reg |-> !ramFromCell;
  endproperty
  a_start_main: assert property (p_start_main) else $error("cell used at start");
  sequence s_capture_low;
    resetAct_reg && !resetPrev_reg && !csB_reg && !backup_reg;
  endsequence
  property p_sel_hold_start;
    @(posedge ref_clk) disable iff (!nrst) s_capture_low |=> !chipSelOut_n && selHold_reg;
  endproperty
  a_sel_hold_start: assert property (p_sel_hold_start) else $error("select hold missing");
  property p_cs_pass;
    @(posedge ref_clk) disable iff (!nrst) !resetAct_reg |=> chipSelOut_n == $past(csB_reg);
  endproperty
  a_cs_pass: assert property (p_cs_pass) else $error("select not passed");
  property p_cs_high_held;
    @(posedge ref_clk) disable iff (!nrst)
      (resetAct_reg && resetPrev_reg && !selHold_reg) |=> chipSelOut_n;
  endproperty
  a_cs_high_held: assert property (p_cs_high_held) else $error("select not high");
  property p_wd_clear;
    @(posedge ref_clk) disable iff (!nrst) (kickEdge || resetAct_reg) |=> wdCnt_reg == '0;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog not cleared");
  property p_wd_fire;
    @(posedge ref_clk) disable iff (!nrst) wdFire |=> resetAct_reg;
  endproperty
  a_wd_fire: assert property (p_wd_fire) else $error("no watchdog reset");
  property p_trip_reset;
    @(posedge ref_clk) disable iff (!nrst) belowTrip |=> resetAct_reg;
  endproperty
  a_trip_reset: assert property (p_trip_reset) else $error("trip not reset");
  sequence s_release;
    resetAct_reg ##1 !resetAct_reg;
  endsequence
  property p_hold;
    @(posedge ref_clk) disable iff (!nrst) s_release |-> $past(holdCnt_reg, 1) == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("hold too short");
  property p_backup_reset;
    @(posedge ref_clk) disable iff (!nrst) backup_reg |=> resetAct_reg;
  endproperty
  a_backup_reset: assert property (p_backup_reset) else $error("backup without reset");
endmodule

// [verification/cpu_ram_model.sv]
`timescale 1ns/1ps
module cpu_ram_model
  import supervisor_pkg::*;
(
  input  wire logic    ref_clk,   // Clock
  input  wire pin_type resetPin,  // Supervisor reset pin
  input  wire logic    selRam_n,  // Gated RAM select
  output logic         inReset,   // Processor held in reset
  output int           selCount   // RAM select cycles in reset
);
  // Push-pull and open-drain low builds only; open-drain high needs a pull level
  assign inReset = resetPin.oe && !resetPin.out;
  int cnt = 0;
  assign selCount = cnt;
  always @(posedge ref_clk) begin
    if (inReset && !selRam_n)
      cnt <= cnt + 1;
  end
endmodule

// [verification/supply_supervisor_tb.sv]
`timescale 1ns/1ps
module supply_supervisor_tb;
  import supervisor_pkg::*;
  localparam int HOLD = 50;
  localparam int WDP  = 200;
  logic       ref_clk;
  logic       nrst;
  supply_type supplyIn;
  logic       kick;
  logic       kickOn;
  logic       kickOnce;
  logic       chipSelIn_n;
  logic       chipSelOut_n;
  pin_type    resetPin;
  logic       flag;
  logic       fromCell;
  logic       fromMain;
  logic       inReset;
  int         selCount;
  int         mismatches;
  int         comparisons;
  int         cycles = 0;
  int         n;

  supply_supervisor #(.AUX_FUNC(AUX_WATCHDOG), .RESET_HOLD_CYC(HOLD),
    .WATCHDOG_PERIOD_CYC(WDP)) dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .supplyIn(supplyIn),
    .manual_reset_n(1'b1), .watchdog_kick_in(kick), .auxUnderIn(1'b0),
    .chipSelIn_n(chipSelIn_n), .chipSelOut_n(chipSelOut_n),
    .resetPin(resetPin), .backup_active_flag(flag),
    .ramFromCell(fromCell), .ramFromMain(fromMain));

  cpu_ram_model partner_u (.ref_clk(ref_clk), .resetPin(resetPin),
    .selRam_n(chipSelOut_n), .inReset(inReset), .selCount(selCount));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  task automatic check(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic in_range(input string what, input int lo, input int hi, input int got);
    comparisons++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
    end
  endtask

  // Bounded wait; a miss returns the limit and fails the range
  task automatic wait_rst(input logic lvl, input int lim, output int k);
    k = 0;
    while (inReset !== lvl && k < lim) begin
      tick(1);
      k++;
    end
  endtask

  task automatic dip(input logic csAt, input int relAt, input int lo, input int hi);
    int base;
    tick(1);
    chipSelIn_n <= csAt;
    tick(5);
    check("select passes", csAt, chipSelOut_n);
    supplyIn.supplyBelowTrip <= 1'b1;
    wait_rst(1'b1, 10, n);
    in_range("reset on low supply", 1, 8, n);
    base = selCount;
    for (int i = 0; i < 300; i++) begin
      chipSelIn_n <= csAt ? i[0] : (i >= relAt);
      tick(1);
    end
    in_range("select low in reset", lo, hi, selCount - base);
    check("select parked high", 1'b1, chipSelOut_n);
    supplyIn.supplyBelowTrip <= 1'b0;
    chipSelIn_n <= 1'b1;
    wait_rst(1'b0, HOLD + 30, n);
    in_range("hold after supply", HOLD, HOLD + 12, n);
  endtask

  task automatic watchdog_test();
    logic seen;
    seen = 1'b0;
    repeat (480) begin
      tick(1);
      seen |= inReset;
    end
    check("reset while kicked", 1'b0, seen);
    kickOn <= 1'b0;
    kickOnce <= 1'b1;
    tick(1);
    kickOnce <= 1'b0;
    wait_rst(1'b1, WDP + 30, n);
    in_range("first timeout", WDP - 2, WDP + 10, n);
    wait_rst(1'b0, HOLD + 30, n);
    in_range("pulse length", HOLD - 2, HOLD + 10, n);
    wait_rst(1'b1, WDP + 30, n);
    in_range("repeat timeout", WDP - 4, WDP + 10, n);
    kickOn <= 1'b1;
    wait_rst(1'b0, HOLD + 30, n);
  endtask

  task automatic backup_test();
    tick(1);
    supplyIn.supplyBelowTrip <= 1'b1;
    tick(8);
    check("main above cell", 1'b1, fromMain);
    supplyIn.supplyBelowCell <= 1'b1;
    chipSelIn_n <= 1'b0;
    tick(8);
    check("cell feeds RAM", 1'b1, fromCell);
    check("main cut off", 1'b0, fromMain);
    check("reset in backup", 1'b1, inReset);
    check("select in backup", 1'b1, chipSelOut_n);
    check("status absent", 1'b0, flag);
    supplyIn <= '{1'b0, 1'b0, 1'b1};
    chipSelIn_n <= 1'b1;
    wait_rst(1'b0, HOLD + 30, n);
    check("main back", 1'b1, fromMain);
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d, comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Background kicks keep the watchdog quiet between scenarios
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if ((kickOn && cycles % 40 == 0) || kickOnce)
      kick <= ~kick;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    mismatches = 0;
    comparisons = 0;
    kickOn = 1'b1;
    kickOnce = 1'b0;
    kick = 1'b0;
    nrst = 1'b0;
    supplyIn = '{1'b0, 1'b0, 1'b0};
    chipSelIn_n = 1'b1;
    tick(10);
    nrst <= 1'b1;
    tick(HOLD + 20);
    check("no start without main", 1'b1, inReset);
    check("cell unused at start", 1'b0, fromCell);
    supplyIn.mainPresent <= 1'b1;
    wait_rst(1'b0, HOLD + 30, n);
    in_range("startup hold", HOLD, HOLD + 12, n);
    check("main at start", 1'b1, fromMain);
    dip(1'b1, 0, 0, 0);
    dip(1'b0, 1000, 234, 246);
    dip(1'b0, 20, 18, 30);
    watchdog_test();
    backup_test();
    report_and_stop();
  end
endmodule
